/* File: hw/mode_reg_bank.v */
// Mode-register bank and multi-purpose training command decoder for one channel.
`timescale 1ns/1ps
`include "mode_regs_map.vh"
module mode_reg_bank (
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  // Mode register write and read commands
  input wire mrw_valid,
  input wire mrr_valid,
  input wire [5:0] mr_addr,
  input wire [7:0] mr_wdata,
  // Multi-purpose command, both operand halves captured together
  input wire mpc_valid,
  input wire [6:0] mpc_op,
  // Column command with burst choice bit
  input wire cas_valid,
  input wire cas_bl_bit,
  input wire cas2_valid,
  input wire [5:0] cas2_op,
  // Device state inputs
  input wire [1:0] zq_pin_sense,
  input wire [2:0] refresh_rate_in,
  input wire [15:0] osc_count_in,
  input wire [7:0] repair_error_in,
  // Read data
  output reg [7:0] mr_rdata,
  output reg mr_rvalid,
  // Training strobes
  output reg train_rd_fifo,
  output reg train_rd_dq_cal,
  output reg train_wr_fifo,
  output reg osc_run,
  output reg cas2_operand_fault,
  // Active operating settings
  output reg [5:0] burst_len,
  output reg rd_preamble_toggle,
  output reg [2:0] write_recovery_clocks,
  output reg read_postamble_len,
  output reg factory_trim,
  output reg zq_busy_out,
  output reg [7:0] dq_cal_pattern
);
  // ----------------------------------------------------------------
  // Plain registers
  // ----------------------------------------------------------------
  reg write_set_point_select;
  reg operating_set_point_select;
  reg [5:0] fsp_ctl_low;
  reg [7:0] cal_pattern_a;
  reg [7:0] cal_pattern_b;
  reg [7:0] lower_byte_cal_invert;
  reg [7:0] upper_byte_cal_invert;
  reg [7:0] bank_mask;
  reg [7:0] segment_mask;
  reg [7:0] oscillator_run_time;
  reg [7:0] ca_reference_cfg;
  reg [7:0] dq_reference_cfg;
  reg [7:0] row_hammer_cfg;
  reg [7:0] repair_control;
  reg [7:0] calibration_reset_ctl;
  reg [7:0] host_termination_cfg;
  reg [3:0] refresh_writable;
  reg temp_update_flag;
  reg [2:0] last_rate;
  reg pending_cas2;
  reg [1:0] pending_kind;
  reg [6:0] next_cmd;
  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  function is_write;
    input [5:0] a;
    begin
      is_write = mrw_valid && (mr_addr == a);
    end
  endfunction
  wire mpc_train = mpc_valid && mpc_op[`BIT_MPC_TRAIN];
  wire [5:0] mpc_code = mpc_op[5:0];
  wire zq_start = mpc_train && (mpc_code == `MPC_ZQ_START);
  wire zq_latch = mpc_train && (mpc_code == `MPC_ZQ_LATCH);
  // ----------------------------------------------------------------
  // Set-point registers
  // ----------------------------------------------------------------
  wire [7:0] sp_op [0:3];
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_sp
      set_point_pair u_pair (
        .clk_sys(clk_sys),
        .srst(srst),
        .wr_en(is_write(g == 0 ? `ADDR_BURST_PREAMBLE_RECOVERY_CFG :
                        g == 1 ? `ADDR_LATENCY_CFG :
                        g == 2 ? `ADDR_IO_DRIVE_INVERSION_CFG :
                        `ADDR_TERMINATION_CFG)),
        .write_set_point_select(write_set_point_select),
        .wr_data(mr_wdata),
        .operating_set_point_select(operating_set_point_select),
        .rd_view(),
        .op_view(sp_op[g])
      );
    end
  endgenerate
  // ----------------------------------------------------------------
  // ZQ self-test
  // ----------------------------------------------------------------
  wire [1:0] zq_self_test_result;
  wire zq_fault;
  wire zq_busy;
  zq_self_test u_zq (
    .clk_sys(clk_sys),
    .srst(srst),
    .zq_start(zq_start),
    .zq_latch(zq_latch),
    .zq_pin_sense(zq_pin_sense),
    .zq_self_test_result(zq_self_test_result),
    .zq_fault(zq_fault),
    .zq_busy(zq_busy)
  );
  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Read-only and vendor test addresses have no write path at all, so
  // a stray write there changes no register, though any write still cancels a pending CAS-2 training.
  always @(posedge clk_sys) begin
    if (srst) begin
      write_set_point_select <= 1'b0;
      operating_set_point_select <= 1'b0;
      fsp_ctl_low <= 6'h00;
      cal_pattern_a <= `RST_CAL_PATTERN_A;
      cal_pattern_b <= `RST_CAL_PATTERN_A;
      lower_byte_cal_invert <= `RST_ZERO;
      upper_byte_cal_invert <= `RST_ZERO;
      bank_mask <= `RST_ZERO;
      segment_mask <= `RST_ZERO;
      oscillator_run_time <= `RST_ZERO;
      ca_reference_cfg <= `RST_ZERO;
      dq_reference_cfg <= `RST_ZERO;
      row_hammer_cfg <= `RST_ZERO;
      repair_control <= `RST_ZERO;
      calibration_reset_ctl <= `RST_ZERO;
      host_termination_cfg <= `RST_ZERO;
      refresh_writable <= 4'h0;
    end else begin
      if (is_write(`ADDR_SET_POINT_TRAINING_CTL)) begin
        write_set_point_select <= mr_wdata[`BIT_WRITE_SET_POINT_SELECT];
        operating_set_point_select <= mr_wdata[`BIT_OPERATING_SET_POINT_SELECT];
        fsp_ctl_low <= mr_wdata[5:0];
      end
      if (is_write(`ADDR_CAL_PATTERN_A)) begin
        cal_pattern_a <= mr_wdata;
      end
      if (is_write(`ADDR_CAL_PATTERN_B)) begin
        cal_pattern_b <= mr_wdata;
      end
      if (is_write(`ADDR_LOWER_BYTE_CAL_INVERT)) begin
        lower_byte_cal_invert <= mr_wdata;
      end
      if (is_write(`ADDR_UPPER_BYTE_CAL_INVERT)) begin
        upper_byte_cal_invert <= mr_wdata;
      end
      if (is_write(`ADDR_BANK_MASK)) begin
        bank_mask <= mr_wdata;
      end
      if (is_write(`ADDR_SEGMENT_MASK)) begin
        segment_mask <= mr_wdata;
      end
      if (is_write(`ADDR_OSCILLATOR_RUN_TIME)) begin
        oscillator_run_time <= mr_wdata;
      end
      if (is_write(`ADDR_CA_REFERENCE_CFG)) begin
        ca_reference_cfg <= mr_wdata;
      end
      if (is_write(`ADDR_DQ_REFERENCE_CFG)) begin
        dq_reference_cfg <= mr_wdata;
      end
      if (is_write(`ADDR_ROW_HAMMER_CFG)) begin
        row_hammer_cfg <= mr_wdata;
      end
      if (is_write(`ADDR_REPAIR_CONTROL)) begin
        repair_control <= mr_wdata;
      end
      if (is_write(`ADDR_CALIBRATION_RESET_CTL)) begin
        calibration_reset_ctl <= mr_wdata;
      end
      if (is_write(`ADDR_HOST_TERMINATION_CFG)) begin
        host_termination_cfg <= mr_wdata;
      end
      if (is_write(`ADDR_REFRESH_THERMAL_STATE)) begin
        refresh_writable <= mr_wdata[6:3];
      end
    end
  end
  // ----------------------------------------------------------------
  // Temperature update flag
  // ----------------------------------------------------------------
  // A rate change in the same cycle as a read keeps the flag set.
  always @(posedge clk_sys) begin
    if (srst) begin
      temp_update_flag <= 1'b0;
      last_rate <= 3'h3;
    end else begin
      last_rate <= refresh_rate_in;
      if (refresh_rate_in != last_rate) begin
        temp_update_flag <= 1'b1;
      end else if (mrr_valid && mr_addr == `ADDR_REFRESH_THERMAL_STATE) begin
        temp_update_flag <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  reg [7:0] next_rdata;
  always @* begin
    next_rdata = 8'h00;
    case (mr_addr)
      `ADDR_DEVICE_FEATURE_INFO: begin
        next_rdata = 8'h00;
        next_rdata[`BIT_ZQ_HI:`BIT_ZQ_LO] = zq_self_test_result;
        next_rdata[`BIT_LATENCY_MODE] = 1'b0;
      end
      `ADDR_REFRESH_THERMAL_STATE: begin
        next_rdata = {temp_update_flag, refresh_writable, refresh_rate_in};
      end
      `ADDR_ORGANISATION_INFO: next_rdata = `RST_ORGANISATION;
      `ADDR_CA_REFERENCE_CFG: next_rdata = ca_reference_cfg;
      `ADDR_DQ_REFERENCE_CFG: next_rdata = dq_reference_cfg;
      `ADDR_OSCILLATOR_COUNT_LOW: next_rdata = osc_count_in[7:0];
      `ADDR_OSCILLATOR_COUNT_HIGH: next_rdata = osc_count_in[15:8];
      `ADDR_ROW_HAMMER_CFG: next_rdata = row_hammer_cfg;
      `ADDR_REPAIR_CONTROL: next_rdata = repair_control;
      `ADDR_REPAIR_ERROR_COUNT: next_rdata = repair_error_in;
      default: next_rdata = 8'h00;
    endcase
  end
  always @(posedge clk_sys) begin
    if (srst) begin
      mr_rdata <= 8'h00;
      mr_rvalid <= 1'b0;
    end else begin
      mr_rvalid <= mrr_valid;
      if (mrr_valid) mr_rdata <= next_rdata;
    end
  end
  // ----------------------------------------------------------------
  // Training command decode
  // ----------------------------------------------------------------
  // Data training waits for its CAS-2 so the latency reference matches a normal access.
  always @* begin
    next_cmd = 7'h00;
    if (mpc_train) begin
      case (mpc_code)
        `MPC_RD_FIFO: next_cmd = 7'h01;
        `MPC_RD_DQ_CAL: next_cmd = 7'h02;
        `MPC_WR_FIFO: next_cmd = 7'h03;
        default: next_cmd = 7'h00;
      endcase
    end
  end
  always @(posedge clk_sys) begin
    if (srst) begin
      pending_cas2 <= 1'b0;
      pending_kind <= 2'h0;
      train_rd_fifo <= 1'b0;
      train_rd_dq_cal <= 1'b0;
      train_wr_fifo <= 1'b0;
      osc_run <= 1'b0;
      cas2_operand_fault <= 1'b0;
    end else begin
      train_rd_fifo <= 1'b0;
      train_rd_dq_cal <= 1'b0;
      train_wr_fifo <= 1'b0;
      cas2_operand_fault <= 1'b0;
      if (next_cmd != 7'h00) begin
        pending_cas2 <= 1'b1;
        pending_kind <= next_cmd[1:0];
      end else if (pending_cas2 && cas2_valid) begin
        pending_cas2 <= 1'b0;
        cas2_operand_fault <= (cas2_op != 6'h00);
        train_rd_fifo <= (pending_kind == 2'h1);
        train_rd_dq_cal <= (pending_kind == 2'h2);
        train_wr_fifo <= (pending_kind == 2'h3);
      end else if (pending_cas2 && (mpc_valid || mrw_valid || mrr_valid || cas_valid)) begin
        pending_cas2 <= 1'b0;
      end
      if (mpc_train && mpc_code == `MPC_OSC_START) osc_run <= 1'b1;
      else if (mpc_train && mpc_code == `MPC_OSC_STOP) osc_run <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // Active settings
  // ----------------------------------------------------------------
  wire [1:0] bl_field = sp_op[0][`BIT_BL_HI:`BIT_BL_LO];
  always @(posedge clk_sys) begin
    if (srst) begin
      burst_len <= `BURST_TRAINING;
      rd_preamble_toggle <= 1'b0;
      write_recovery_clocks <= 3'h0;
      read_postamble_len <= 1'b0;
      factory_trim <= 1'b0;
      zq_busy_out <= 1'b0;
      dq_cal_pattern <= `RST_CAL_PATTERN_A;
    end else begin
      if (pending_cas2 && cas2_valid && pending_kind != 2'h2) begin
        burst_len <= `BURST_TRAINING;
      end else if (cas_valid) begin
        if (bl_field == `BL_FIXED_16) burst_len <= `BURST_TRAINING;
        else if (bl_field == `BL_FIXED_32) burst_len <= `BURST_LONG;
        else burst_len <= cas_bl_bit ? `BURST_LONG : `BURST_TRAINING;
      end
      rd_preamble_toggle <= sp_op[0][`BIT_RD_PRE];
      write_recovery_clocks <= sp_op[0][`BIT_NWR_HI:`BIT_NWR_LO];
      read_postamble_len <= sp_op[0][`BIT_READ_POSTAMBLE_LEN];
      factory_trim <= zq_fault;
      zq_busy_out <= zq_busy;
      dq_cal_pattern <= cal_pattern_a;
    end
  end
endmodule

/* File: hw/mode_regs_map.vh */
// Register offsets, field positions, reset values and timing counts for the mode-register bank.
`ifndef MODE_REGS_MAP_VH
`define MODE_REGS_MAP_VH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_DEVICE_FEATURE_INFO 6'h00
`define ADDR_BURST_PREAMBLE_RECOVERY_CFG 6'h01
`define ADDR_LATENCY_CFG 6'h02
`define ADDR_IO_DRIVE_INVERSION_CFG 6'h03
`define ADDR_REFRESH_THERMAL_STATE 6'h04
`define ADDR_ORGANISATION_INFO 6'h08
`define ADDR_CALIBRATION_RESET_CTL 6'h0A
`define ADDR_TERMINATION_CFG 6'h0B
`define ADDR_CA_REFERENCE_CFG 6'h0C
`define ADDR_SET_POINT_TRAINING_CTL 6'h0D
`define ADDR_DQ_REFERENCE_CFG 6'h0E
`define ADDR_LOWER_BYTE_CAL_INVERT 6'h0F
`define ADDR_BANK_MASK 6'h10
`define ADDR_SEGMENT_MASK 6'h11
`define ADDR_OSCILLATOR_COUNT_LOW 6'h12
`define ADDR_OSCILLATOR_COUNT_HIGH 6'h13
`define ADDR_UPPER_BYTE_CAL_INVERT 6'h14
`define ADDR_HOST_TERMINATION_CFG 6'h16
`define ADDR_OSCILLATOR_RUN_TIME 6'h17
`define ADDR_ROW_HAMMER_CFG 6'h18
`define ADDR_VENDOR_TEST_A 6'h1E
`define ADDR_CAL_PATTERN_A 6'h20
`define ADDR_REPAIR_CONTROL 6'h21
`define ADDR_REPAIR_ERROR_COUNT 6'h22
`define ADDR_VENDOR_TEST_B 6'h27
`define ADDR_CAL_PATTERN_B 6'h28
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_MPC_TRAIN 6
`define BIT_LATENCY_MODE 1
`define BIT_ZQ_LO 3
`define BIT_ZQ_HI 4
`define BIT_CA_TERMINATION_RANK_INFO 7
`define BIT_BL_LO 0
`define BIT_BL_HI 1
`define BIT_RD_PRE 3
`define BIT_NWR_LO 4
`define BIT_NWR_HI 6
`define BIT_READ_POSTAMBLE_LEN 7
`define BIT_WRITE_SET_POINT_SELECT 6
`define BIT_OPERATING_SET_POINT_SELECT 7
`define BIT_TUF 7
// ----------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------
`define MPC_RD_FIFO 6'h01
`define MPC_RD_DQ_CAL 6'h03
`define MPC_WR_FIFO 6'h07
`define MPC_OSC_START 6'h0D
`define MPC_OSC_STOP 6'h0E
`define MPC_ZQ_START 6'h0F
`define MPC_ZQ_LATCH 6'h11
`define ZQ_RESISTOR_OK 2'h3
`define ZQ_FAULT_A 2'h1
`define ZQ_FAULT_B 2'h2
`define BL_FIXED_16 2'h0
`define BL_FIXED_32 2'h1
`define RST_CAL_PATTERN_A 8'h5A
`define RST_ZERO 8'h00
`define RST_ORGANISATION 8'h00
`define BURST_TRAINING 6'd16
`define BURST_LONG 6'd32
// ----------------------------------------------------------------
// Timing counts at 20 MHz
// ----------------------------------------------------------------
`define CLK_PERIOD_PS 50000
`define ZQ_CAL_TIME_NS 1000
`define ZQ_CAL_CYCLES ((`ZQ_CAL_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define ZQ_LATCH_TIME_NS 30
`define ZQ_LATCH_CYCLES ((`ZQ_LATCH_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`endif

/* File: hw/set_point_pair.v */
// Two physical copies of one set-point register.
`timescale 1ns/1ps
module set_point_pair (
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  // Write side
  input wire wr_en,
  input wire write_set_point_select,
  input wire [7:0] wr_data,
  // Selects
  input wire operating_set_point_select,
  // Views
  output wire [7:0] rd_view,
  output wire [7:0] op_view
);
  reg [7:0] copy_0;
  reg [7:0] copy_1;
  always @(posedge clk_sys) begin
    if (srst) begin
      copy_0 <= 8'h00;
      copy_1 <= 8'h00;
    end else if (wr_en) begin
      if (write_set_point_select) begin
        copy_1 <= wr_data;
      end else begin
        copy_0 <= wr_data;
      end
    end
  end
  assign rd_view = write_set_point_select ? copy_1 : copy_0;
  assign op_view = operating_set_point_select ? copy_1 : copy_0;
endmodule

/* File: hw/zq_self_test.v */
// ZQ calibration sequencer and self-test result holder.
`timescale 1ns/1ps
`include "mode_regs_map.vh"
module zq_self_test (
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  // Commands
  input wire zq_start,
  input wire zq_latch,
  input wire [1:0] zq_pin_sense,
  // Status
  output reg [1:0] zq_self_test_result,
  output reg zq_fault,
  output reg zq_busy
);
  localparam ST_IDLE = 2'd0;
  localparam ST_CAL = 2'd1;
  localparam ST_DONE = 2'd2;
  localparam ST_LATCH = 2'd3;
  reg [1:0] state;
  reg [7:0] count;
  localparam [31:0] CAL_LAST = `ZQ_CAL_CYCLES - 1;
  localparam [31:0] LATCH_LAST = `ZQ_LATCH_CYCLES - 1;
  always @(posedge clk_sys) begin
    if (srst) begin
      state <= ST_IDLE;
      count <= 8'h00;
      zq_self_test_result <= 2'h0;
      zq_fault <= 1'b0;
      zq_busy <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (zq_start && !zq_fault) begin
            state <= ST_CAL;
            count <= 8'h00;
            zq_busy <= 1'b1;
          end
        end
        ST_CAL: begin
          if (count == CAL_LAST[7:0]) begin
            state <= ST_DONE;
            zq_busy <= 1'b0;
          end else begin
            count <= count + 8'h01;
          end
        end
        ST_DONE: begin
          if (zq_latch && !zq_fault) begin
            state <= ST_LATCH;
            count <= 8'h00;
            zq_busy <= 1'b1;
          end
        end
        ST_LATCH: begin
          if (count == LATCH_LAST[7:0]) begin
            state <= ST_IDLE;
            zq_busy <= 1'b0;
            zq_self_test_result <= zq_pin_sense;
            zq_fault <= (zq_pin_sense == `ZQ_FAULT_A) || (zq_pin_sense == `ZQ_FAULT_B);
          end else begin
            count <= count + 8'h01;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

/* File: tb/mode_regs_props.sv */
// Concurrent checks on the ports of the mode-register bank.
`timescale 1ns/1ps
module mode_regs_props (
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  // Commands
  input wire mrr_valid,
  input wire mpc_valid,
  input wire [6:0] mpc_op,
  input wire cas2_valid,
  input wire [5:0] cas2_op,
  // Results
  input wire mr_rvalid,
  input wire train_rd_fifo,
  input wire train_rd_dq_cal,
  input wire train_wr_fifo,
  input wire osc_run,
  input wire cas2_operand_fault,
  input wire [5:0] burst_len,
  input wire factory_trim
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // A training command taken, then CAS-2 with low operands on the next slot.
  sequence s_train(c);
    mpc_valid && mpc_op == c ##1 cas2_valid && cas2_op == 6'h00 && !mpc_valid;
  endsequence
  a_read_answer: assert property (mrr_valid |=> mr_rvalid)
    else $error("read answer missing");
  a_read_quiet: assert property (!mrr_valid |=> !mr_rvalid)
    else $error("read answer without read");
  a_wr_fifo_go: assert property (s_train(7'h47) |=> train_wr_fifo)
    else $error("buffer write training not started");
  a_rd_fifo_go: assert property (s_train(7'h41) |=> train_rd_fifo && !train_wr_fifo)
    else $error("buffer read training not started");
  a_dq_cal_go: assert property (s_train(7'h43) |=> train_rd_dq_cal)
    else $error("calibration read not started");
  a_nop_quiet: assert property (mpc_valid && !mpc_op[6] ##1 cas2_valid |=>
    !train_wr_fifo && !train_rd_fifo && !train_rd_dq_cal)
    else $error("no-op started a training");
  a_fifo_burst: assert property (train_wr_fifo || train_rd_fifo |-> burst_len == 6'd16)
    else $error("buffer training burst not sixteen");
  a_cas2_fault: assert property (mpc_valid && mpc_op == 7'h47 ##1 cas2_valid && cas2_op != 6'h00
    |=> cas2_operand_fault)
    else $error("nonzero CAS-2 operands not flagged");
  a_strobe_cause: assert property ($rose(train_wr_fifo) |-> $past(cas2_valid))
    else $error("training strobe without CAS-2");
  a_osc_start: assert property (mpc_valid && mpc_op == 7'h4D |=> osc_run)
    else $error("oscillator did not start");
  a_trim_sticky: assert property (factory_trim |=> factory_trim)
    else $error("factory trim dropped");
  c_wr_fifo: cover property (s_train(7'h47));
  c_fault: cover property (cas2_valid && cas2_op != 6'h00);
  c_trim: cover property (factory_trim);
endmodule

/* File: tb/host_ctrl.sv */
// Memory-controller model that issues mode-register and training commands.
`timescale 1ns/1ps
module host_ctrl (
  // Clock
  input wire clk_sys,
  // Commands
  output logic mrw_valid,
  output logic mrr_valid,
  output logic [5:0] mr_addr,
  output logic [7:0] mr_wdata,
  output logic mpc_valid,
  output logic [6:0] mpc_op,
  output logic cas_valid,
  output logic cas_bl_bit,
  output logic cas2_valid,
  output logic [5:0] cas2_op,
  // Read answer
  input wire [7:0] mr_rdata,
  input wire mr_rvalid
);
  initial begin
    {mrw_valid, mrr_valid, mpc_valid, cas_valid, cas2_valid} = 5'h00;
    {mr_addr, mr_wdata, mpc_op, cas_bl_bit, cas2_op} = 28'h0;
  end
  // Released lines show the inverse, so a stale value cannot pass for a fresh one.
  task mrw(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    mrw_valid = 1'b1;
    mr_addr = a;
    mr_wdata = d;
    @(negedge clk_sys);
    mrw_valid = 1'b0;
    mr_addr = ~a;
    mr_wdata = ~d;
  endtask
  task mrr(input logic [5:0] a, output logic [7:0] d, output logic ok);
    @(negedge clk_sys);
    mrr_valid = 1'b1;
    mr_addr = a;
    @(negedge clk_sys);
    mrr_valid = 1'b0;
    mr_addr = ~a;
    ok = 1'b0;
    d = 8'h00;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (mr_rvalid === 1'b1) begin
        d = mr_rdata;
        ok = 1'b1;
      end else begin
        @(negedge clk_sys);
      end
    end
  endtask
  // CAS-2 follows the training command on the very next slot.
  task mpc(input logic en, input logic [6:0] op, input logic c2, input logic [5:0] c2op);
    @(negedge clk_sys);
    mpc_valid = en;
    mpc_op = op;
    @(negedge clk_sys);
    mpc_valid = 1'b0;
    mpc_op = ~op;
    if (c2) begin
      cas2_valid = 1'b1;
      cas2_op = c2op;
      @(negedge clk_sys);
      cas2_valid = 1'b0;
      cas2_op = ~c2op;
    end
  endtask
  // Normal column commands are only sent outside training pairs.
  task cas(input logic bl);
    @(negedge clk_sys);
    cas_valid = 1'b1;
    cas_bl_bit = bl;
    @(negedge clk_sys);
    cas_valid = 1'b0;
    cas_bl_bit = ~bl;
  endtask
endmodule

/* File: tb/test_sdram_mode_regs_and_training_cmds.sv */
// Self-checking bench for the mode-register bank.
`timescale 1ns/1ps
module test_sdram_mode_regs_and_training_cmds;
  logic clk_sys, srst;
  logic [1:0] zq_pin_sense;
  logic [2:0] refresh_rate_in;
  logic [15:0] osc_count_in;
  logic [7:0] repair_error_in;
  wire mrw_valid, mrr_valid, mpc_valid, cas_valid, cas_bl_bit, cas2_valid;
  wire [5:0] mr_addr, cas2_op, burst_len;
  wire [7:0] mr_wdata, mr_rdata, dq_cal_pattern;
  wire [6:0] mpc_op;
  wire [2:0] write_recovery_clocks;
  wire mr_rvalid, train_rd_fifo, train_rd_dq_cal, train_wr_fifo, osc_run;
  wire cas2_operand_fault, rd_preamble_toggle, read_postamble_len, factory_trim, zq_busy_out;
  integer mismatches = 0;
  integer samples_checked = 0;
  integer seed;
  logic [7:0] rw_mem [0:63];
  logic [1:0] zq_exp;
  logic [7:0] d, v;
  logic ok;
  logic [5:0] addr_tab [0:10] = '{6'h0C, 6'h0E, 6'h18, 6'h21, 6'h00, 6'h12, 6'h22,
    6'h1E, 6'h27, 6'h3F, 6'h20};
  logic [6:0] tr_op [0:2] = '{7'h41, 7'h43, 7'h47};
  mode_reg_bank DUT (
    .clk_sys, .srst, .mrw_valid, .mrr_valid, .mr_addr, .mr_wdata, .mpc_valid, .mpc_op,
    .cas_valid, .cas_bl_bit, .cas2_valid, .cas2_op, .zq_pin_sense, .refresh_rate_in,
    .osc_count_in, .repair_error_in, .mr_rdata, .mr_rvalid, .train_rd_fifo, .train_rd_dq_cal,
    .train_wr_fifo, .osc_run, .cas2_operand_fault, .burst_len, .rd_preamble_toggle,
    .write_recovery_clocks, .read_postamble_len, .factory_trim, .zq_busy_out, .dq_cal_pattern
  );
  host_ctrl host (
    .clk_sys, .mrw_valid, .mrr_valid, .mr_addr, .mr_wdata, .mpc_valid, .mpc_op,
    .cas_valid, .cas_bl_bit, .cas2_valid, .cas2_op, .mr_rdata, .mr_rvalid
  );
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Reads of write-only, reserved and test places return zero.
  function logic [7:0] exp_rd(input logic [5:0] a);
    case (a)
      6'h00: exp_rd = {3'h0, zq_exp, 3'h0};
      6'h0C, 6'h0E, 6'h18, 6'h21: exp_rd = rw_mem[a];
      6'h12: exp_rd = osc_count_in[7:0];
      6'h13: exp_rd = osc_count_in[15:8];
      6'h22: exp_rd = repair_error_in;
      default: exp_rd = 8'h00;
    endcase
  endfunction
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task hang;
    mismatches++;
    $display("CHECK FAILED wait expected done seen timeout");
    end_sim;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task rd_chk(input logic [5:0] ra);
    host.mrr(ra, v, ok);
    if (!ok) hang;
    else chk("mr_rdata", exp_rd(ra), v);
  endtask
  // A short calibration stretch is chosen, so the wait bound stays small.
  task zq_cmd(input logic [6:0] op);
    integer n;
    host.mpc(1'b1, op, 1'b0, 6'h00);
    repeat (3) @(negedge clk_sys);
    n = 0;
    while (zq_busy_out !== 1'b0 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 40) hang;
    else repeat (2) @(negedge clk_sys);
  endtask
  initial begin
    seed = 32'h3453;
    srst = 1'b1;
    zq_pin_sense = 2'h3;
    refresh_rate_in = 3'h3;
    osc_count_in = 16'($random(seed));
    repair_error_in = 8'($random(seed));
    zq_exp = 2'h0;
    repeat (6) @(negedge clk_sys);
    srst = 1'b0;
    chk("burst_len", 8'd16, {2'h0, burst_len});
    chk("dq_cal_pattern", 8'h5A, dq_cal_pattern);
    rd_chk(6'h00);
    // ----------------------------------------------------------------
    // Access classes
    // ----------------------------------------------------------------
    for (int i = 0; i < 11; i++) begin
      d = 8'($random(seed));
      host.mrw(addr_tab[i], d);
      rw_mem[addr_tab[i]] = d;
      rd_chk(addr_tab[i]);
    end
    chk("dq_cal_pattern", d, dq_cal_pattern);
    rd_chk(6'h13);
    // ----------------------------------------------------------------
    // Set points and burst fields
    // ----------------------------------------------------------------
    host.mrw(6'h0D, 8'h40);
    d = {1'b1, 3'($random(seed)), 2'b11, 2'b01};
    host.mrw(6'h01, d);
    host.cas(1'b1);
    repeat (2) @(negedge clk_sys);
    chk("burst_len", 8'd16, {2'h0, burst_len});
    chk("rd_preamble_toggle", 8'h00, {7'h0, rd_preamble_toggle});
    host.mrw(6'h0D, 8'hC0);
    host.cas(1'b0);
    repeat (2) @(negedge clk_sys);
    chk("burst_len", 8'd32, {2'h0, burst_len});
    chk("rd_preamble_toggle", 8'h01, {7'h0, rd_preamble_toggle});
    chk("write_recovery_clocks", {5'h0, d[6:4]}, {5'h0, write_recovery_clocks});
    chk("read_postamble_len", 8'h01, {7'h0, read_postamble_len});
    rd_chk(6'h01);
    for (int j = 0; j < 3; j++) begin
      // Idle gap that covers the turnaround limits between trainings.
      repeat (16) @(negedge clk_sys);
      host.mpc(1'b1, tr_op[j], 1'b1, 6'h00);
      chk("train", {5'h0, 3'b100 >> j}, {5'h0, train_rd_fifo, train_rd_dq_cal, train_wr_fifo});
      if (j != 1) chk("burst_len", 8'd16, {2'h0, burst_len});
    end
    host.mpc(1'b1, 7'h47, 1'b0, 6'h00);
    host.mrw(6'h3F, 8'h00);
    host.mpc(1'b0, 7'h00, 1'b1, 6'h00);
    chk("train", 8'h00, {5'h0, train_rd_fifo, train_rd_dq_cal, train_wr_fifo});
    host.mpc(1'b1, 7'h07, 1'b1, 6'h00);
    chk("train", 8'h00, {5'h0, train_rd_fifo, train_rd_dq_cal, train_wr_fifo});
    host.mpc(1'b1, 7'h47, 1'b1, 6'h15);
    chk("cas2_operand_fault", 8'h01, {7'h0, cas2_operand_fault});
    host.mrw(6'h01, {d[7:2], 2'b10});
    host.cas(1'b1);
    repeat (2) @(negedge clk_sys);
    chk("burst_len", 8'd32, {2'h0, burst_len});
    host.cas(1'b0);
    repeat (2) @(negedge clk_sys);
    chk("burst_len", 8'd16, {2'h0, burst_len});
    host.mrw(6'h0D, 8'h00);
    repeat (2) @(negedge clk_sys);
    chk("rd_preamble_toggle", 8'h00, {7'h0, rd_preamble_toggle});
    host.mpc(1'b1, 7'h4D, 1'b0, 6'h00);
    chk("osc_run", 8'h01, {7'h0, osc_run});
    host.mpc(1'b1, 7'h4E, 1'b0, 6'h00);
    chk("osc_run", 8'h00, {7'h0, osc_run});
    // ----------------------------------------------------------------
    // Calibration self-test
    // ----------------------------------------------------------------
    refresh_rate_in = 3'($random(seed));
    zq_cmd(7'h4F);
    rd_chk(6'h00);
    zq_cmd(7'h51);
    zq_exp = 2'h3;
    rd_chk(6'h00);
    chk("factory_trim", 8'h00, {7'h0, factory_trim});
    srst = 1'b1;
    repeat (2) @(negedge clk_sys);
    srst = 1'b0;
    zq_exp = 2'h0;
    rd_chk(6'h00);
    zq_pin_sense = 2'h1;
    zq_cmd(7'h4F);
    zq_cmd(7'h51);
    zq_exp = 2'h1;
    rd_chk(6'h00);
    chk("factory_trim", 8'h01, {7'h0, factory_trim});
    zq_pin_sense = 2'h3;
    host.mpc(1'b1, 7'h4F, 1'b0, 6'h00);
    repeat (3) @(negedge clk_sys);
    chk("zq_busy_out", 8'h00, {7'h0, zq_busy_out});
    end_sim;
  end
endmodule
bind mode_reg_bank mode_regs_props u_props (
  .clk_sys, .srst, .mrr_valid, .mpc_valid, .mpc_op, .cas2_valid, .cas2_op, .mr_rvalid,
  .train_rd_fifo, .train_rd_dq_cal, .train_wr_fifo, .osc_run, .cas2_operand_fault,
  .burst_len, .factory_trim
);
